// [gtc_pkg.sv]
// Package of constants, register map and carrier types for the gated timer/counter.
package gtc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CFG      = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO   = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_CMP_LO   = 8'h14;
  localparam logic [7:0] ADDR_CMP_HI   = 8'h18;
  localparam logic [7:0] ADDR_CCU      = 8'h1C;
  localparam logic [7:0] ADDR_PINS     = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and field constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [4:0]  CFG_RST       = 5'h00;
  localparam logic [2:0]  CCU_RST       = 3'h0;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES  = 16'hFFFF;
  localparam logic [15:0] CMP_RST       = 16'h0000;
  localparam logic [2:0]  PRE_RST       = 3'h0;
  localparam logic [1:0]  PIN_DIR_IN    = 2'h3;
  localparam logic [1:0]  PIN_PORT_ZERO = 2'h0;
  localparam int          INSTR_DIV     = 4;
  localparam logic [1:0]  INSTR_LAST    = 2'(INSTR_DIV - 1);
  localparam logic [1:0]  INSTR_RST     = 2'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       gate_invert;
    logic       gate_enable;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_disable;
    logic       source_select;
    logic       counter_on;
  } gtc_ctrl_t;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic overflow_irq_enable;
    logic gate_from_comparator;
    logic alt_clock_select;
  } gtc_cfg_t;

  typedef struct packed {
    logic special_event_en;
    logic compare_en;
    logic capture_en;
  } gtc_ccu_t;

endpackage : gtc_pkg

// [gtc_timer.sv]
// Gated 16-bit timer/counter with APB register access.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - 16-bit count in two bytes; a byte write replaces that byte at once.
// - Source: instruction clock, system clock, or external pin, per select bits.
// - External source counts on each rising edge of the counter pin.
// - External rising edges are ignored until a falling edge has been seen.
// - Prescaler divides the chosen clock by 1, 2, 4 or 8.
// - Prescaler is hidden from software and cleared by any count byte write.
// - Oscillator enable starts the crystal oscillator, only with a suitable primary.
// - With oscillator on, its pins read as inputs with port bits zero.
// - Sync disable counts external edges without the synchroniser.
// - Asynchronous counter mode keeps counting in sleep and may wake.
// - No capture/compare time base in async mode or system clock mode.
// - Count reads in asynchronous mode always return a settled value.
// - Gate comes from pin or comparator two, effective only when enabled.
// - Gate invert applies whichever gate source is selected.
// - Rollover from all ones to zero sets the overflow flag.
// - Interrupt needs all three enables; flag holds until software clears.
// - Overflow in sleep wakes when on with overflow and peripheral enables.
// - Capture copies count to compare pair; compare fires on equality.
// - Special event clears the count without setting the overflow flag.
// - A count byte write beats a simultaneous special event clear.
// - Prescale codes: 11 by 8, 10 by 4, 01 by 2, 00 by 1.
// - Gate enable makes counting follow the gate; otherwise counts always.
// - Invert set counts while gate high; clear counts while gate low.
module gtc_timer (
  input  wire logic        clk,                    // System clock, 125 MHz.
  input  wire logic        nrst,                   // Asynchronous reset, active low.
  input  wire logic        psel,                   // APB select.
  input  wire logic        penable,                // APB access phase.
  input  wire logic        pwrite,                 // APB write direction.
  input  wire logic [7:0]  paddr,                  // APB byte address.
  input  wire logic [31:0] pwdata,                 // APB write data.
  output logic      [31:0] prdata,                 // APB read data.
  output logic             pready,                 // APB ready.
  output logic             pslverr,                // APB error on unmapped address.
  input  wire logic        external_counter_input, // External counter pin.
  input  wire logic        gate_input_pin,         // Gate pin.
  input  wire logic        comparator_two_output,  // Comparator two output.
  input  wire logic        sleep,                  // Processor is asleep.
  input  wire logic        primary_osc_ok,         // Primary clock allows the crystal.
  input  wire logic        capture_event,          // Capture event from the unit.
  input  wire logic [1:0]  osc_pin_port_in,        // Port bits of the oscillator pins.
  input  wire logic [1:0]  osc_pin_dir_in,         // Direction bits of those pins.
  output logic      [1:0]  osc_pin_port_rd,        // Port bits as software reads them.
  output logic      [1:0]  osc_pin_dir_rd,         // Direction bits as software reads.
  output logic             osc_pin_force_input,    // Oscillator pins forced to input.
  output logic             crystal_osc_run,        // Crystal oscillator running.
  output logic             time_base_valid,        // Count usable as time base.
  output logic             compare_event,          // Compare match pulse.
  output logic             irq_out,                // Interrupt request to processor.
  output logic             wake_out                // Wake request from sleep.
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Registers and bus decode
  // ----------------------------------------------------------------
  gtc_pkg::gtc_ctrl_t ctrl_q;
  gtc_pkg::gtc_cfg_t  cfg_q;
  gtc_pkg::gtc_ccu_t  ccu_q;
  logic [15:0] cnt_q;
  logic [15:0] cmp_q;
  logic [2:0]  pre_q;
  logic [1:0]  instr_q;
  logic        ovf_flag_q;
  logic        armed_q;
  logic        match_q;
  logic [31:0] prdata_q;
  logic        wr_en;
  logic        wr_lo;
  logic        wr_hi;
  logic        mapped;
  logic        inc;
  logic        ovf_set;
  logic        special_clr;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign wr_lo   = wr_en & (paddr == gtc_pkg::ADDR_CNT_LO);
  assign wr_hi   = wr_en & (paddr == gtc_pkg::ADDR_CNT_HI);
  assign mapped  = (paddr == gtc_pkg::ADDR_CTRL) | (paddr == gtc_pkg::ADDR_CFG) |
                   (paddr == gtc_pkg::ADDR_CNT_LO) | (paddr == gtc_pkg::ADDR_CNT_HI) |
                   (paddr == gtc_pkg::ADDR_STATUS) | (paddr == gtc_pkg::ADDR_CMP_LO) |
                   (paddr == gtc_pkg::ADDR_CMP_HI) | (paddr == gtc_pkg::ADDR_CCU) |
                   (paddr == gtc_pkg::ADDR_PINS);
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= gtc_pkg::CTRL_RST;
      cfg_q  <= gtc_pkg::CFG_RST;
      ccu_q  <= gtc_pkg::CCU_RST;
    end else if (wr_en) begin
      case (paddr)
        gtc_pkg::ADDR_CTRL: ctrl_q <= pwdata[7:0];
        gtc_pkg::ADDR_CFG:  cfg_q  <= pwdata[4:0];
        gtc_pkg::ADDR_CCU:  ccu_q  <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data is latched in the setup cycle, so it is settled for the access phase.
  // Settled count reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        gtc_pkg::ADDR_CTRL:   prdata_q <= {24'h000000, ctrl_q};
        gtc_pkg::ADDR_CFG:    prdata_q <= {27'h0000000, cfg_q};
        gtc_pkg::ADDR_CNT_LO: prdata_q <= {24'h000000, cnt_q[7:0]};
        gtc_pkg::ADDR_CNT_HI: prdata_q <= {24'h000000, cnt_q[15:8]};
        gtc_pkg::ADDR_STATUS: prdata_q <= {31'h00000000, ovf_flag_q};
        gtc_pkg::ADDR_CMP_LO: prdata_q <= {24'h000000, cmp_q[7:0]};
        gtc_pkg::ADDR_CMP_HI: prdata_q <= {24'h000000, cmp_q[15:8]};
        gtc_pkg::ADDR_CCU:    prdata_q <= {29'h00000000, ccu_q};
        gtc_pkg::ADDR_PINS:   prdata_q <= {28'h0000000, osc_pin_dir_rd, osc_pin_port_rd};
        default:              prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and pin overrides
  // ----------------------------------------------------------------
  // Crystal start
  assign crystal_osc_run     = ctrl_q.crystal_osc_enable & primary_osc_ok;
  assign osc_pin_force_input = crystal_osc_run;
  assign osc_pin_dir_rd      = crystal_osc_run ? gtc_pkg::PIN_DIR_IN : osc_pin_dir_in;
  assign osc_pin_port_rd     = crystal_osc_run ? gtc_pkg::PIN_PORT_ZERO : osc_pin_port_in;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_raw_q;
  logic ext_mode;
  logic async_mode;
  logic ext_rise;
  logic ext_fall;
  logic instr_tick;
  logic src_tick;

  // Two-stage synchroniser, edges taken after it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
      ext_s3_q  <= 1'b0;
      ext_raw_q <= 1'b0;
    end else begin
      ext_s1_q  <= external_counter_input;
      ext_s2_q  <= ext_s1_q;
      ext_s3_q  <= ext_s2_q;
      ext_raw_q <= external_counter_input;
    end
  end

  assign ext_mode   = ctrl_q.source_select;
  assign async_mode = ext_mode & ctrl_q.sync_disable;

  always_comb begin
    if (async_mode) begin
      ext_rise = external_counter_input & ~ext_raw_q;
      ext_fall = ~external_counter_input & ext_raw_q;
    end else begin
      ext_rise = ext_s2_q & ~ext_s3_q;
      ext_fall = ~ext_s2_q & ext_s3_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (!ext_mode || !ctrl_q.counter_on) begin
      armed_q <= 1'b0;
    end else if (ext_fall) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q <= gtc_pkg::INSTR_RST;
    end else begin
      instr_q <= instr_q + 2'h1;
    end
  end
  assign instr_tick = (instr_q == gtc_pkg::INSTR_LAST);

  // Source select; rising edges; only async runs in sleep
  always_comb begin
    if (ext_mode) begin
      src_tick = ext_rise & armed_q & (~sleep | async_mode);
    end else if (cfg_q.alt_clock_select) begin
      src_tick = ~sleep;
    end else begin
      src_tick = instr_tick & ~sleep;
    end
  end

  // ----------------------------------------------------------------
  // Gate, prescaler and count
  // ----------------------------------------------------------------
  logic       gate_src;
  logic       gate_ok;
  logic       run_tick;
  logic [2:0] pre_last;

  assign gate_src = cfg_q.gate_from_comparator ? comparator_two_output : gate_input_pin;
  assign gate_ok  = ~ctrl_q.gate_enable | (ctrl_q.gate_invert ? gate_src : ~gate_src);
  assign run_tick = ctrl_q.counter_on & gate_ok & src_tick;

  always_comb begin
    case (ctrl_q.prescale_select)
      2'h0:    pre_last = 3'h0;
      2'h1:    pre_last = 3'h1;
      2'h2:    pre_last = 3'h3;
      2'h3:    pre_last = 3'h7;
      default: pre_last = 3'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= gtc_pkg::PRE_RST;
    end else if (wr_lo | wr_hi) begin
      pre_q <= gtc_pkg::PRE_RST;
    end else if (run_tick) begin
      pre_q <= (pre_q >= pre_last) ? gtc_pkg::PRE_RST : pre_q + 3'h1;
    end
  end

  assign inc     = run_tick & (pre_q >= pre_last);
  assign ovf_set = inc & (cnt_q == gtc_pkg::CNT_ALL_ONES) & ~(wr_lo | wr_hi) & ~special_clr;

  // Byte writes; write beats clear; clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= gtc_pkg::CNT_RST;
    end else if (wr_lo | wr_hi) begin
      cnt_q[7:0]  <= wr_lo ? pwdata[7:0] : cnt_q[7:0];
      cnt_q[15:8] <= wr_hi ? pwdata[7:0] : cnt_q[15:8];
    end else if (special_clr) begin
      cnt_q <= gtc_pkg::CNT_RST;
    end else if (inc) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Set wins over a clear in the same cycle; writing one clears the flag.
  // Rollover flag; held until cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_q <= 1'b1;
    end else if (wr_en && paddr == gtc_pkg::ADDR_STATUS && pwdata[0]) begin
      ovf_flag_q <= 1'b0;
    end
  end

  assign irq_out  = ovf_flag_q & cfg_q.overflow_irq_enable & cfg_q.peripheral_irq_enable &
                    cfg_q.global_irq_enable;
  assign wake_out = sleep & ctrl_q.counter_on & ovf_flag_q & cfg_q.overflow_irq_enable &
                    cfg_q.peripheral_irq_enable;

  // ----------------------------------------------------------------
  // Capture and compare time base
  // ----------------------------------------------------------------
  logic cmp_equal;

  // No time base in async or system clock mode
  assign time_base_valid = ~async_mode & (ext_mode | ~cfg_q.alt_clock_select);
  assign cmp_equal       = ccu_q.compare_en & time_base_valid & (cnt_q == cmp_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= cmp_equal;
    end
  end
  assign compare_event = cmp_equal & ~match_q;
  assign special_clr   = compare_event & ccu_q.special_event_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= gtc_pkg::CMP_RST;
    end else if (capture_event && ccu_q.capture_en && time_base_valid) begin
      cmp_q <= cnt_q;
    end else if (wr_en && paddr == gtc_pkg::ADDR_CMP_LO) begin
      cmp_q[7:0] <= pwdata[7:0];
    end else if (wr_en && paddr == gtc_pkg::ADDR_CMP_HI) begin
      cmp_q[15:8] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_steady_instr;
    ctrl_q.counter_on && !ctrl_q.source_select && !cfg_q.alt_clock_select &&
    !ctrl_q.gate_enable && ctrl_q.prescale_select == 2'h0 && !sleep && !psel;
  endsequence

  sequence s_inc_at_top;
    inc && cnt_q == gtc_pkg::CNT_ALL_ONES && !(wr_lo | wr_hi) && !special_clr;
  endsequence

  AST_WRITE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    wr_lo |=> cnt_q[7:0] == $past(pwdata[7:0]))
    else $error("Low byte write did not reach the count.");

  AST_WRITE_OVER_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_hi && special_clr) |=> cnt_q[15:8] == $past(pwdata[7:0]))
    else $error("Special clear beat a count write.");

  AST_PRESCALE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_lo || wr_hi) |=> pre_q == gtc_pkg::PRE_RST)
    else $error("Prescaler not cleared by count write.");

  AST_ROLLOVER_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    s_inc_at_top |=> ovf_flag_q && cnt_q == gtc_pkg::CNT_RST)
    else $error("Rollover did not set the flag.");

  AST_SPECIAL_NO_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    (special_clr && !ovf_flag_q && !(wr_lo | wr_hi)) |=> !ovf_flag_q && cnt_q == gtc_pkg::CNT_RST)
    else $error("Special clear set the flag or kept the count.");

  AST_STOPPED_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_q.counter_on && !(wr_lo | wr_hi) && !special_clr) |=> $stable(cnt_q))
    else $error("Count moved while stopped.");

  AST_PINS_FORCED: assert property (@(posedge clk) disable iff (!rst_n)
    crystal_osc_run |-> osc_pin_dir_rd == gtc_pkg::PIN_DIR_IN &&
                        osc_pin_port_rd == gtc_pkg::PIN_PORT_ZERO)
    else $error("Oscillator pins not shown as inputs.");

  AST_GATE_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_q.gate_enable && (ctrl_q.gate_invert != gate_src)) |-> !inc)
    else $error("Count advanced with the gate closed.");

  AST_ARM_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_mode && !armed_q) |-> !inc)
    else $error("External edge counted before a falling edge.");

  AST_INSTR_RATE: assert property (@(posedge clk) disable iff (!rst_n)
    (inc && !(wr_lo | wr_hi) && !special_clr) ##0 s_steady_instr [*5] |->
    inc && !$past(inc) && !$past(inc, 2) && !$past(inc, 3))
    else $error("Instruction clock rate is not one in four.");

  AST_IRQ_GATING: assert property (@(posedge clk) disable iff (!rst_n)
    (ovf_flag_q && !cfg_q.global_irq_enable) |-> !irq_out)
    else $error("Interrupt raised without global enable.");

endmodule : gtc_timer

`default_nettype wire

// [gtc_far_side.sv]
// Far-side model: external counter pulses and gate pin level.
`timescale 1ns/10ps
`default_nettype none
module gtc_far_side (
  input  wire logic       clk,      // System clock.
  input  wire logic       start,    // Launch a burst, one cycle.
  input  wire logic [7:0] pulses,   // Pulses in the burst.
  input  wire logic       gate_lvl, // Gate level to present.
  output logic            ext_pin,  // External counter pin.
  output logic            gate_pin, // Gate pin.
  output logic            busy      // Burst in flight.
);
  logic [7:0] left_q = 8'h00;
  logic [2:0] ph_q   = 3'h0;
  // pulses of four cycles low then four high; pin stands low between bursts.
  always_ff @(posedge clk) begin
    gate_pin <= gate_lvl;
    ph_q     <= (start || left_q != 8'h00) ? ph_q + 3'h1 : 3'h0;
    if (start) begin
      left_q <= pulses;
    end else if (left_q != 8'h00 && ph_q == 3'h7) begin
      left_q <= left_q - 8'h01;
    end
    ext_pin <= (left_q != 8'h00) && ph_q[2];
  end
  assign busy = (left_q != 8'h00);
endmodule : gtc_far_side
`default_nettype wire

// [gtc_timer_test.sv]
// Self-checking bench for the gated timer/counter.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_test;
  logic        clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, fs_pulses = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, err_seen, ext_pin, gate_pin, busy;
  logic        fs_start = 1'h0, gate_lvl = 1'h0, cmp2 = 1'h0, sleep = 1'h0;
  logic        posc_ok = 1'h0, cap_ev = 1'h0, force_in, osc_run, tbv, cmp_ev, irq, wake;
  logic [1:0]  port_rd, dir_rd;
  logic [15:0] cnt;
  int          bad_count = 0, checks_done = 0, ev_count = 0;

  always #4 clk = ~clk;
  always @(negedge clk) if (cmp_ev === 1'h1) ev_count <= ev_count + 1;

  gtc_timer i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_counter_input(ext_pin), .gate_input_pin(gate_pin),
    .comparator_two_output(cmp2), .sleep(sleep), .primary_osc_ok(posc_ok),
    .capture_event(cap_ev), .osc_pin_port_in(2'h1), .osc_pin_dir_in(2'h2),
    .osc_pin_port_rd(port_rd), .osc_pin_dir_rd(dir_rd), .osc_pin_force_input(force_in),
    .crystal_osc_run(osc_run), .time_base_valid(tbv), .compare_event(cmp_ev),
    .irq_out(irq), .wake_out(wake));
  gtc_far_side i_far (.clk(clk), .start(fs_start), .pulses(fs_pulses), .gate_lvl(gate_lvl),
    .ext_pin(ext_pin), .gate_pin(gate_pin), .busy(busy));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chk_near(input string nm, input int exp, input logic [15:0] seen, input int tol);
    checks_done++;
    if ($isunknown(seen) || int'(seen) > exp + tol || int'(seen) + tol < exp) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : chk_near

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rdv      = prdata;
    err_seen = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic read_cnt();
    apb(1'h0, gtc_pkg::ADDR_CNT_LO, 8'h00);
    cnt[7:0] = rdv[7:0];
    apb(1'h0, gtc_pkg::ADDR_CNT_HI, 8'h00);
    cnt[15:8] = rdv[7:0];
  endtask : read_cnt

  task automatic run(input logic [7:0] ctrl, input logic [7:0] cfg, input logic [7:0] p,
                     input int n);
    // counter stopped before its bytes are written
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CNT_LO, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CNT_HI, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CFG, cfg);
    apb(1'h1, gtc_pkg::ADDR_CTRL, ctrl);
    fs_pulses <= p;
    fs_start  <= (p != 8'h00);
    @(posedge clk);
    fs_start  <= 1'h0;
    repeat (n) @(posedge clk);
    apb(1'h1, gtc_pkg::ADDR_CTRL, ctrl & 8'hFE);
    read_cnt();
  endtask : run

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, 8'(i * 4), 8'h00);
      chk("reset value", 16'h0000, rdv[15:0]);
    end
    apb(1'h0, 8'h40, 8'h00);
    chk("unmapped data", 16'h0000, rdv[15:0]);
    chk("unmapped error", 16'h0001, 16'(err_seen));
  endtask : t_reset

  task automatic t_prescale();
    for (int ps = 0; ps < 4; ps++) begin
      run(8'h01 | 8'(ps << 4), 8'h00, 8'h00, 80 << ps);
      chk_near("prescaled count", ((80 << ps) + 4) / (4 << ps), cnt, 1);
    end
    run(8'h01, 8'h01, 8'h00, 40);
    chk_near("system clock count", 44, cnt, 1);
    chk("no time base on system clock", 16'h0000, 16'(tbv));
  endtask : t_prescale

  task automatic t_external();
    run(8'h03, 8'h00, 8'h05, 100);
    chk("synced pulses", 16'h0004, cnt);
    sleep <= 1'h1;
    run(8'h07, 8'h00, 8'h05, 100);
    chk("async pulses in sleep", 16'h0004, cnt);
    chk("no time base async", 16'h0000, 16'(tbv));
    sleep <= 1'h0;
  endtask : t_external

  task automatic t_gate();
    logic [7:0] ctl [5] = '{8'h41, 8'hC1, 8'h01, 8'hC1, 8'h41};
    logic [7:0] cfg [5] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03};
    int         exp [5] = '{0, 44, 44, 0, 44};
    gate_lvl <= 1'h1;
    cmp2     <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      run(ctl[i], cfg[i], 8'h00, 40);
      chk_near("gated count", exp[i], cnt, (exp[i] == 0) ? 0 : 1);
    end
  endtask : t_gate

  task automatic t_overflow();
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CNT_LO, 8'hFD);
    apb(1'h1, gtc_pkg::ADDR_CNT_HI, 8'hFF);
    apb(1'h1, gtc_pkg::ADDR_CFG, 8'h1D);
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h01);
    repeat (10) @(posedge clk);
    apb(1'h0, gtc_pkg::ADDR_STATUS, 8'h00);
    chk("overflow flag", 16'h0001, rdv[15:0]);
    chk("irq all enables", 16'h0001, 16'(irq));
    sleep <= 1'h1;
    @(posedge clk);
    chk("wake in sleep", 16'h0001, 16'(wake));
    sleep <= 1'h0;
    apb(1'h1, gtc_pkg::ADDR_CFG, 8'h0D);
    chk("irq without global", 16'h0000, 16'(irq));
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_STATUS, 8'h01);
    apb(1'h0, gtc_pkg::ADDR_STATUS, 8'h00);
    chk("flag cleared", 16'h0000, rdv[15:0]);
  endtask : t_overflow

  task automatic t_compare();
    int ev;
    apb(1'h1, gtc_pkg::ADDR_CNT_LO, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CNT_HI, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CMP_LO, 8'h04);
    apb(1'h1, gtc_pkg::ADDR_CMP_HI, 8'h00);
    apb(1'h1, gtc_pkg::ADDR_CCU, 8'h06);
    apb(1'h1, gtc_pkg::ADDR_CFG, 8'h00);
    ev = ev_count;
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h01);
    chk("time base valid", 16'h0001, 16'(tbv));
    repeat (100) @(posedge clk);
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h00);
    read_cnt();
    chk("count within period", 16'h0001, 16'(cnt <= 16'h0004));
    chk("compare events", 16'h0001, 16'(ev_count - ev > 3));
    apb(1'h0, gtc_pkg::ADDR_STATUS, 8'h00);
    chk("no flag on event clear", 16'h0000, rdv[15:0]);
  endtask : t_compare

  task automatic t_capture();
    apb(1'h1, gtc_pkg::ADDR_CNT_LO, 8'h34);
    apb(1'h1, gtc_pkg::ADDR_CNT_HI, 8'h12);
    read_cnt();
    chk("count bytes", 16'h1234, cnt);
    apb(1'h1, gtc_pkg::ADDR_CCU, 8'h01);
    cap_ev <= 1'h1;
    @(posedge clk);
    cap_ev <= 1'h0;
    @(posedge clk);
    apb(1'h0, gtc_pkg::ADDR_CMP_LO, 8'h00);
    chk("captured low", 16'h0034, {8'h00, rdv[7:0]});
    apb(1'h0, gtc_pkg::ADDR_CMP_HI, 8'h00);
    chk("captured high", 16'h0012, {8'h00, rdv[7:0]});
  endtask : t_capture

  task automatic t_osc();
    posc_ok <= 1'h1;
    // oscillator enabled alone, counter left off
    apb(1'h1, gtc_pkg::ADDR_CTRL, 8'h08);
    chk("crystal runs", 16'h0001, 16'(osc_run));
    chk("pins forced input", 16'h0001, 16'(force_in));
    chk("pin outputs forced", 16'h000C, {12'h000, dir_rd, port_rd});
    apb(1'h0, gtc_pkg::ADDR_PINS, 8'h00);
    chk("pin bits forced", 16'h000C, rdv[15:0]);
    posc_ok <= 1'h0;
    @(posedge clk);
    chk("crystal held off", 16'h0000, 16'(osc_run));
    apb(1'h0, gtc_pkg::ADDR_PINS, 8'h00);
    chk("pin bits pass", 16'h0009, rdv[15:0]);
    chk("pin outputs pass", 16'h0009, {12'h000, dir_rd, port_rd});
  endtask : t_osc

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    repeat (4) @(posedge clk);
    t_reset();
    t_prescale();
    t_external();
    t_gate();
    t_overflow();
    t_compare();
    t_capture();
    t_osc();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule : gtc_timer_test
`default_nettype wire
